// File: serial_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on a 32-bit Avalon-MM bus, one register per word
// Notes: definitions only; the FIFO, top and bench files include it by name
// How it works
// - Two sixteen-entry FIFOs: transmit eight bits wide, receive twelve
// - Five to eight data bits, both directions
// - Even, odd, stick or no parity, generated and checked
// - One or two stop bits per sent character
// - FIFO levels at 1/8, 1/4, 1/2, 3/4, 7/8
// - Break sent on output, break seen on input
// - Low-power pulse clock divides by 1 to 256
// - Infrared pulses 3/16 bit or low-power width
// - Transmit and receive enables both set after reset
// - Disabling mid character finishes that character first
// - Start, data LSB first, parity, stop bits
// - Overrun, parity, framing, break stored with each character
// - Divisor: 16-bit whole plus 6-bit fraction
// - Sixteen ticks per bit, transmit and receive
// - Divisor and line control load on line write
// - Busy until FIFO empty and last stop sent
// - Frames follow back to back until FIFO empty
// - Start bit valid only if low at tick eight
// - Data and parity sampled every sixteenth tick
// - Low stop sample is framing error; store character
// - FIFOs one deep until FIFO enable set
// - Data read twelve bits, write pushes eight
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH
`define FIFO_DEPTH 16
`define OFS_DATA 6'h00
`define OFS_FLAG 6'h18
`define OFS_ILPR 6'h20
`define OFS_IBRD 6'h24
`define OFS_FBRD 6'h28
`define OFS_LCRH 6'h2c
`define OFS_CTL 6'h30
`define OFS_IFLS 6'h34
`define CTL_EN 0
`define CTL_IR 1
`define CTL_LP 2
`define CTL_TXE 8
`define CTL_RXE 9
`define CTL_RESET 16'h0300
`define IFLS_RESET 6'h12
`define LCRH_BRK 0
`define LCRH_PEN 1
`define LCRH_EPS 2
`define LCRH_STP2 3
`define LCRH_FEN 4
`define LCRH_WLEN 5
`define LCRH_SPS 7
`define FLG_BUSY 3
`define SUB_LAST 4'hf
`define START_SAMPLE 4'h7
`define IR_PULSE 4'h3
`define LP_PULSE 2'h3
`define IR_HOLD 5'h10
`endif

// File: serial_pkg.sv
// Purpose: shared types of the serial transceiver
// Assumes: nothing beyond the map header
// Notes: state enums only; per-module state structs live in the modules
package serial_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage

// File: serial_fifo.sv
// Purpose: flip-flop FIFO with a one-entry mode
// Assumes: push and pop are single-cycle strobes
// Notes: a push when full or a pop when empty is ignored
`timescale 1ns/100ps
`include "serial_map.svh"
module serial_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic deep,
   input wire logic push,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic pop,
   output logic [WIDTH-1:0] rdata,
   output logic [$clog2(DEPTH):0] count,
   output logic empty,
   output logic full
);
   import serial_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_t;
   fifo_t st, next_st;
   logic do_push, do_pop;

   // Capacity drops to one entry while the FIFO is switched off
   assign empty = st.cnt == '0;
   assign full = st.cnt >= (deep ? (AW+1)'(DEPTH) : (AW+1)'(1));
   assign count = st.cnt;
   assign rdata = st.mem[st.rp];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   // Pointer and count update
   always_comb begin
      next_st = st;
      if (do_push) begin
         next_st.mem[st.wp] = wdata;
         next_st.wp = AW'(st.wp + 1'b1);
      end
      if (do_pop) begin
         next_st.rp = AW'(st.rp + 1'b1);
      end
      next_st.cnt = (AW+1)'(st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

// File: serial_baud.sv
// Purpose: fractional divider making the 16x oversampling tick
// Assumes: divisor holds still between line-control writes
// Notes: a zero whole part stops the tick altogether
`timescale 1ns/100ps
module serial_baud (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] div_int,
   input wire logic [5:0] div_frac,
   output logic tick
);
   import serial_pkg::*;
   typedef struct packed {
      logic [16:0] cnt;
      logic [5:0] acc;
      logic tick;
   } baud_t;
   baud_t st, next_st;
   logic [6:0] sum;

   // Period is the whole part, stretched by one when the fraction carries
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      sum = {1'b0, st.acc} + {1'b0, div_frac};
      if (div_int == 16'h0) begin
         next_st.cnt = 17'h0;
      end else if (st.cnt <= 17'h1) begin
         next_st.acc = sum[5:0];
         next_st.cnt = {1'b0, div_int} + {16'h0, sum[6]};
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 17'h1;
      end
   end

   assign tick = st.tick;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

// File: serial_top.sv
// Purpose: async serial transceiver with FIFOs, behind Avalon-MM registers
// Assumes: serial_in_pin already synchronous to clk; clk at 200 MHz
// Notes: every access answers with waitrequest low one cycle after it appears
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "serial_map.svh"
module serial_top #(
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic serial_in_pin,
   output logic serial_out_pin
);
   import serial_pkg::*;
   localparam int CW = $clog2(DEPTH) + 1;

   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic [15:0] ibrd;
      logic [5:0] fbrd;
      logic [29:0] shadow;
      logic [15:0] ctl;
      logic [5:0] ifls;
      logic [7:0] ilpr;
      logic [7:0] lp_cnt;
      logic [1:0] lp_pulse;
      tx_state_t tx_state;
      logic [3:0] tx_sub;
      logic [2:0] tx_bit;
      logic [7:0] tx_shift;
      logic tx_par;
      logic txo;
      rx_state_t rx_state;
      logic [3:0] rx_sub;
      logic [2:0] rx_bit;
      logic [7:0] rx_shift;
      logic rx_perr;
      logic rx_zero;
      logic rx_prev;
      logic [4:0] ir_hold;
      logic ovr;
   } state_t;
   state_t st, next_st;

   logic tick, take, lp_tick, line, bitv, logical, busy, can_send, stop_end, tx_go;
   logic en, tx_on, rx_on, ir, irlp, brk, pen, eps, sps, stp2, fifo_on_bit;
   logic [1:0] wlen;
   logic [2:0] last_bit;
   logic [7:0] lcrh, tx_rdata, rx_data;
   logic [11:0] rx_rdata, rx_wdata;
   logic tx_push, tx_empty, tx_full, rx_push, rx_pop, rx_empty, rx_full;
   logic rx_sample, tx_lvl, rx_lvl;
   logic [CW-1:0] tx_count, rx_count;

   // Parity bit for the active character length
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
         input logic ev, input logic stick);
      logic x;
      x = ^(d & (8'hff >> (2'd3 - wl)));
      par_bit = stick ? !ev : (ev ? x : !x);
   endfunction

   // Fill level that marks a FIFO trigger point
   function automatic logic [CW-1:0] thr(input logic [2:0] sel);
      case (sel)
         3'h0: thr = CW'(DEPTH / 8);
         3'h1: thr = CW'(DEPTH / 4);
         3'h2: thr = CW'(DEPTH / 2);
         3'h3: thr = CW'(DEPTH * 3 / 4);
         default: thr = CW'(DEPTH * 7 / 8);
      endcase
   endfunction

   // Live control bits; framing comes from the loaded shadow only
   assign lcrh = st.shadow[7:0];
   assign en = st.ctl[`CTL_EN];
   assign ir = st.ctl[`CTL_IR];
   assign irlp = st.ctl[`CTL_LP];
   assign tx_on = st.ctl[`CTL_TXE];
   assign rx_on = st.ctl[`CTL_RXE];
   assign brk = lcrh[`LCRH_BRK];
   assign pen = lcrh[`LCRH_PEN];
   assign eps = lcrh[`LCRH_EPS];
   assign stp2 = lcrh[`LCRH_STP2];
   assign fifo_on_bit = lcrh[`LCRH_FEN];
   assign sps = lcrh[`LCRH_SPS];
   assign wlen = lcrh[`LCRH_WLEN +: 2];
   assign last_bit = {1'b0, wlen} + 3'h4;

   serial_baud u_baud (
      .clk(clk),
      .rst_n(rst_n),
      .div_int(st.shadow[29:14]),
      .div_frac(st.shadow[13:8]),
      .tick(tick)
   );

   serial_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
      .clk(clk),
      .rst_n(rst_n),
      .deep(fifo_on_bit),
      .push(tx_push),
      .wdata(writedata[7:0]),
      .pop(tx_go),
      .rdata(tx_rdata),
      .count(tx_count),
      .empty(tx_empty),
      .full(tx_full)
   );

   serial_fifo #(.WIDTH(12), .DEPTH(DEPTH)) u_rxf (
      .clk(clk),
      .rst_n(rst_n),
      .deep(fifo_on_bit),
      .push(rx_push),
      .wdata(rx_wdata),
      .pop(rx_pop),
      .rdata(rx_rdata),
      .count(rx_count),
      .empty(rx_empty),
      .full(rx_full)
   );

   // Bus handshake: an access is taken in the cycle waitrequest is low
   assign take = (read || write) && !st.waitreq;
   assign tx_push = take && write && address == `OFS_DATA;
   assign rx_pop = take && read && address == `OFS_DATA;
   assign busy = !tx_empty || st.tx_state != TX_IDLE;
   assign tx_lvl = tx_count <= thr(st.ifls[2:0]);
   assign rx_lvl = rx_count >= thr(st.ifls[5:3]);

   // Transmit sequencing; a new frame may start straight from the last stop tick
   assign can_send = en && tx_on && !tx_empty;
   assign stop_end = st.tx_state == TX_STOP && tick && st.tx_sub == `SUB_LAST
      && (!stp2 || st.tx_bit != 3'h0);
   assign tx_go = can_send && ((st.tx_state == TX_IDLE && tick) || stop_end);
   assign lp_tick = st.lp_cnt == 8'h0;

   // Line level of the current transmit bit
   always_comb begin
      case (st.tx_state)
         TX_START: bitv = 1'b0;
         TX_DATA: bitv = st.tx_shift[0];
         TX_PAR: bitv = st.tx_par;
         default: bitv = 1'b1;
      endcase
      logical = bitv && !brk;
   end

   // Receive input: infrared pulses are stretched to about one bit low
   assign line = ir ? (st.ir_hold == 5'h0) : serial_in_pin;
   assign rx_sample = tick && st.rx_sub == `SUB_LAST;
   assign rx_data = st.rx_shift >> (2'd3 - wlen);
   assign rx_push = st.rx_state == RX_STOP && rx_sample && !rx_full;
   assign rx_wdata = {st.ovr, st.rx_zero && !line, pen && st.rx_perr, !line, rx_data};

   // Next-state logic for registers, transmitter and receiver
   always_comb begin
      next_st = st;
      next_st.waitreq = 1'b1;
      if ((read || write) && st.waitreq) begin
         next_st.waitreq = 1'b0;
         next_st.rdata = 32'h0;
         if (read) begin
            case (address)
               `OFS_DATA: next_st.rdata = {20'h0, rx_rdata};
               `OFS_FLAG: next_st.rdata = {22'h0, rx_lvl, tx_lvl, tx_empty, rx_full,
                  tx_full, rx_empty, busy, 3'h0};
               `OFS_ILPR: next_st.rdata = {24'h0, st.ilpr};
               `OFS_IBRD: next_st.rdata = {16'h0, st.ibrd};
               `OFS_FBRD: next_st.rdata = {26'h0, st.fbrd};
               `OFS_LCRH: next_st.rdata = {24'h0, lcrh};
               `OFS_CTL: next_st.rdata = {16'h0, st.ctl};
               `OFS_IFLS: next_st.rdata = {26'h0, st.ifls};
               default: next_st.rdata = 32'h0;
            endcase
         end
      end
      if (take && write) begin
         case (address)
            `OFS_IBRD: next_st.ibrd = writedata[15:0];
            `OFS_FBRD: next_st.fbrd = writedata[5:0];
            `OFS_LCRH: next_st.shadow = {st.ibrd, st.fbrd, writedata[7:0]};
            `OFS_CTL: next_st.ctl = writedata[15:0];
            `OFS_IFLS: next_st.ifls = writedata[5:0];
            `OFS_ILPR: next_st.ilpr = writedata[7:0];
            default: ;
         endcase
      end

      // Low-power pulse clock; a divisor of zero counts 256
      next_st.lp_cnt = lp_tick ? 8'(st.ilpr - 8'h1) : 8'(st.lp_cnt - 8'h1);
      if (tick && st.tx_sub == 4'h0) begin
         next_st.lp_pulse = `LP_PULSE;
      end else if (lp_tick && st.lp_pulse != 2'h0) begin
         next_st.lp_pulse = st.lp_pulse - 2'h1;
      end

      // Transmitter: sixteen ticks per bit, never dropped mid frame
      if (st.tx_state == TX_IDLE) begin
         next_st.tx_sub = 4'h0;
      end else if (tick) begin
         next_st.tx_sub = st.tx_sub + 4'h1;
         if (st.tx_sub == `SUB_LAST) begin
            case (st.tx_state)
               TX_START: next_st.tx_state = TX_DATA;
               TX_DATA: begin
                  next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                  next_st.tx_bit = st.tx_bit + 3'h1;
                  if (st.tx_bit == last_bit) begin
                     next_st.tx_bit = 3'h0;
                     next_st.tx_state = pen ? TX_PAR : TX_STOP;
                  end
               end
               TX_PAR: next_st.tx_state = TX_STOP;
               default: begin
                  next_st.tx_bit = 3'h1;
                  if (stop_end) begin
                     next_st.tx_state = TX_IDLE;
                  end
               end
            endcase
         end
      end
      if (tx_go) begin
         next_st.tx_state = TX_START;
         next_st.tx_sub = 4'h0;
         next_st.tx_bit = 3'h0;
         next_st.tx_shift = tx_rdata;
         next_st.tx_par = par_bit(tx_rdata, wlen, eps, sps);
      end

      // Output pin, plain or infrared coded; a zero bit becomes a short pulse
      if (!ir) begin
         next_st.txo = logical;
      end else if (irlp) begin
         next_st.txo = !logical && st.lp_pulse != 2'h0;
      end else begin
         next_st.txo = !logical && st.tx_sub < `IR_PULSE;
      end

      // Infrared receive stretch
      if (!serial_in_pin) begin
         next_st.ir_hold = `IR_HOLD;
      end else if (tick && st.ir_hold != 5'h0) begin
         next_st.ir_hold = st.ir_hold - 5'h1;
      end

      // Receiver: needs a high-to-low edge, so a held break cannot retrigger
      next_st.rx_prev = line;
      case (st.rx_state)
         RX_IDLE: begin
            next_st.rx_sub = 4'h0;
            if (st.rx_prev && !line && en && rx_on) begin
               next_st.rx_state = RX_START;
            end
         end
         RX_START: begin
            if (tick) begin
               next_st.rx_sub = st.rx_sub + 4'h1;
               if (st.rx_sub == `START_SAMPLE) begin
                  next_st.rx_sub = 4'h0;
                  next_st.rx_bit = 3'h0;
                  next_st.rx_zero = 1'b1;
                  next_st.rx_state = line ? RX_IDLE : RX_DATA;
               end
            end
         end
         RX_DATA: begin
            if (tick) begin
               next_st.rx_sub = st.rx_sub + 4'h1;
            end
            if (rx_sample) begin
               next_st.rx_shift = {line, st.rx_shift[7:1]};
               next_st.rx_zero = st.rx_zero && !line;
               next_st.rx_bit = st.rx_bit + 3'h1;
               if (st.rx_bit == last_bit) begin
                  next_st.rx_state = pen ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (tick) begin
               next_st.rx_sub = st.rx_sub + 4'h1;
            end
            if (rx_sample) begin
               next_st.rx_perr = line != par_bit(rx_data, wlen, eps, sps);
               next_st.rx_zero = st.rx_zero && !line;
               next_st.rx_state = RX_STOP;
            end
         end
         default: begin
            if (tick) begin
               next_st.rx_sub = st.rx_sub + 4'h1;
            end
            if (rx_sample) begin
               next_st.ovr = rx_full;
               next_st.rx_perr = 1'b0;
               next_st.rx_state = RX_IDLE;
            end
         end
      endcase
   end

   assign readdata = st.rdata;
   assign waitrequest = st.waitreq;
   assign serial_out_pin = st.txo;

   // State register; reset leaves the line at mark and both paths enabled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.waitreq <= 1'b1;
         st.txo <= 1'b1;
         st.rx_prev <= 1'b1;
         st.ctl <= `CTL_RESET;
         st.ifls <= `IFLS_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic idle_mark;
   assign idle_mark = st.tx_state == TX_IDLE && !brk && !ir;

   AST_IDLE_MARK: assert property (idle_mark |=> serial_out_pin)
      else $error("idle transmitter not at mark");
   AST_BREAK_LOW: assert property (brk && !ir |=> !serial_out_pin)
      else $error("break not driven low");
   AST_START_BIT: assert property (tx_go && !ir |=> ##1 !serial_out_pin)
      else $error("start bit not low");
   AST_BIT_TICKS: assert property ($past(st.tx_state) != TX_IDLE
      && st.tx_state != $past(st.tx_state) |-> $past(tick) && $past(st.tx_sub) == 4'hf)
      else $error("transmit bit not sixteen ticks");
   AST_RX_START: assert property (st.rx_state == RX_DATA && $past(st.rx_state) == RX_START
      |-> $past(tick) && $past(st.rx_sub) == 4'h7 && !$past(line))
      else $error("start accepted off the eighth tick");
   AST_BUSY_FLAG: assert property (busy && read && st.waitreq && address == `OFS_FLAG
      |=> !waitrequest && readdata[`FLG_BUSY])
      else $error("busy flag not reported");
   AST_FIFO_CAP: assert property (tx_count <= CW'(DEPTH) && rx_count <= CW'(DEPTH))
      else $error("fifo count beyond depth");
   AST_ONE_DEEP: assert property (!fifo_on_bit && tx_count != '0 |-> tx_full)
      else $error("fifo deeper than one while off");
   AST_SHADOW: assert property (take && write && address != `OFS_LCRH
      |=> $stable(st.shadow))
      else $error("divisor loaded without line write");
   AST_RESET_EN: assert property ($rose(rst_n) |-> tx_on && rx_on)
      else $error("enables not set after reset");
   AST_FINISH: assert property (st.tx_state == TX_DATA && !en |=> st.tx_state != TX_IDLE)
      else $error("character cut short");
   AST_STORE: assert property (rx_push && !line |=> !rx_empty)
      else $error("framing character not stored");

   COV_TX: cover property (tx_go && st.tx_state == TX_STOP);
   COV_RX: cover property (rx_push);
   COV_BRK: cover property (rx_push && rx_wdata[10]);
   COV_RD: cover property (rx_pop);
endmodule

// File: serial_peer.sv
// Purpose: remote serial device facing the transceiver pins
// Assumes: one bit lasts BIT clock cycles
// Notes: idle line is mark; sampling is at mid-bit
`timescale 1ns/100ps
module serial_peer #(
   parameter int BIT = 32
) (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // Frame bits go out LSB first, order built by the caller
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         line_out <= f[i];
         repeat (BIT) @(posedge clk);
      end
      line_out <= 1'b1; // Mark between frames
      // One edge of mark, so back-to-back frames never drive the pin twice at once
      @(posedge clk);
   endtask
   // Low pulse of c clocks: a glitch that must not count as a start, or a break
   task automatic pulse(input int c);
      line_out <= 1'b0;
      repeat (c) @(posedge clk);
      line_out <= 1'b1;
   endtask
   // Stops at mid last bit so a following start edge is not missed
   task automatic recv(input int n, output logic [11:0] f, output time t0);
      int w;
      f = '0;
      w = 0;
      while (line_in === 1'b1 && w < 4000) begin
         @(posedge clk);
         w++;
      end
      t0 = $time;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         f[i] = line_in;
         if (i < n - 1) repeat (BIT) @(posedge clk);
      end
   endtask
endmodule

// File: testbench.sv
// Purpose: self-checking bench for serial_top
// Assumes: divisor 2 gives 32 clocks per bit
// Notes: table rows for framing, hand tests for errors and edges
`timescale 1ns/100ps
`include "serial_map.svh"
module testbench;
   typedef struct {logic [7:0] lc; logic [7:0] d; logic [11:0] x;} row_t;
   logic clk, rst_n, read, write, serial_in_pin, serial_out_pin, waitrequest;
   logic [5:0] address;
   logic [31:0] writedata, readdata, q;
   logic [11:0] f, got;
   time t0, t1;
   int n, n_fail, compares;
   row_t rows[5] = '{'{8'h00, 8'h15, 12'h015}, '{8'h22, 8'h2a, 12'h02a},
      '{8'h4e, 8'h5b, 12'h05b}, '{8'hf6, 8'hc3, 12'h0c3}, '{8'he2, 8'h81, 12'h081}};
   serial_top #(.DEPTH(16)) dut_u (.clk(clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin));
   serial_peer #(.BIT(32)) peer_u (.clk(clk), .line_in(serial_out_pin),
      .line_out(serial_in_pin));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; one idle edge after release
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int w;
      w = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clk);
      while (waitrequest !== 1'b0 && w < 100) begin
         @(posedge clk);
         w++;
      end
      if (w >= 100) n_fail++; // Slave never answered
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cfg(input logic [7:0] lc);
      bus(1, `OFS_CTL, 32'h0300); // Disable before reprogramming
      bus(1, `OFS_LCRH, {24'h0, lc});
      bus(1, `OFS_CTL, 32'h0301);
   endtask
   task automatic wait_rx();
      int w;
      w = 0;
      q = 32'h10;
      while (q[4] !== 1'b0 && w < 100) begin
         bus(0, `OFS_FLAG, 0);
         w++;
      end
      if (q[4] !== 1'b0) n_fail++; // Nothing arrived in time
      bus(0, `OFS_DATA, 0);
   endtask
   // Expected wire frame: start, data LSB first, parity, stop marks
   function automatic logic [11:0] frame(input logic [7:0] lc, input logic [7:0] d,
                                         output int n);
      int w;
      logic p;
      logic [7:0] m;
      logic [11:0] fr;
      w = 5 + int'(lc[6:5]);
      m = 8'hff >> (8 - w);
      p = lc[7] ? !lc[2] : (lc[2] ? ^(d & m) : ~^(d & m));
      fr = 12'hfff;
      fr[0] = 1'b0;
      for (int i = 0; i < w; i++) fr[1 + i] = d[i];
      n = 1 + w;
      if (lc[1]) begin
         fr[n] = p;
         n++;
      end
      n = n + 1 + int'(lc[3]);
      return fr;
   endfunction
   task automatic tx_chk(input logic [7:0] lc, input logic [7:0] d);
      f = frame(lc, d, n);
      peer_u.recv(n, got, t0);
      chk(got, f & ~(12'hfff << n));
   endtask
   // Watchdog sized well above the expected run
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, `OFS_CTL, 0);
      chk(q, 32'h0300);
      bus(0, `OFS_IFLS, 0);
      chk(q, 32'h12);
      bus(0, `OFS_FLAG, 0);
      chk(q & 32'h398, 32'h190);
      bus(0, 6'h3c, 0);
      chk(q, 32'h0); // Unmapped reads as zero
      chk(serial_out_pin, 1);
      bus(1, `OFS_IBRD, 32'h2); // Whole part only, fraction rounds to 0
      bus(1, `OFS_FBRD, 32'h0);
      // Framing table: sent and received with each line setting
      foreach (rows[i]) begin
         cfg(rows[i].lc);
         bus(1, `OFS_DATA, {24'h0, rows[i].d});
         tx_chk(rows[i].lc, rows[i].d);
         peer_u.send(f, n);
         wait_rx();
         chk(q, {20'h0, rows[i].x});
      end
      // Two queued characters leave back to back, busy spans both
      cfg(8'h70);
      bus(1, `OFS_DATA, 32'ha5);
      // Watch for the first start bit while the second character is queued
      fork
         tx_chk(8'h70, 8'ha5);
         begin
            bus(1, `OFS_DATA, 32'h3c);
            bus(0, `OFS_FLAG, 0);
            chk(q[3], 1);
         end
      join
      t1 = t0;
      tx_chk(8'h70, 8'h3c);
      chk(32'(t0 - t1), 32'd1600);
      repeat (40) @(posedge clk);
      bus(0, `OFS_FLAG, 0);
      chk(q[3], 0);
      // Disable in mid character: frame still completes, busy stays up
      bus(1, `OFS_DATA, 32'h96);
      fork
         tx_chk(8'h70, 8'h96);
         begin
            repeat (100) @(posedge clk);
            bus(1, `OFS_CTL, 32'h0300);
            bus(0, `OFS_FLAG, 0);
            chk(q[3], 1);
         end
      join
      // Divisor change without a line write keeps the old bit time
      bus(1, `OFS_IBRD, 32'h7);
      bus(1, `OFS_CTL, 32'h0301);
      bus(1, `OFS_DATA, 32'h5a);
      tx_chk(8'h70, 8'h5a);
      bus(1, `OFS_IBRD, 32'h2);
      // Parity error
      cfg(8'h62);
      f = frame(8'h62, 8'h37, n);
      f[9] = !f[9];
      peer_u.send(f, n);
      wait_rx();
      chk(q[11:8], 4'h2);
      // Framing error, character still stored
      cfg(8'h60);
      f = frame(8'h60, 8'ha5, n);
      f[9] = 1'b0;
      peer_u.send(f, n);
      wait_rx();
      chk(q[8:0], 9'h1a5);
      // Line held low 24 bit times, more than two character times
      peer_u.pulse(24 * 32);
      wait_rx();
      chk(q[10], 1);
      // Low pulse shorter than eight ticks is ignored
      peer_u.pulse(6);
      repeat (700) @(posedge clk);
      bus(0, `OFS_FLAG, 0);
      chk(q[4], 1);
      // One-deep holding register overruns on the second character
      peer_u.send(frame(8'h60, 8'h11, n), n);
      peer_u.send(frame(8'h60, 8'h22, n), n);
      bus(0, `OFS_FLAG, 0);
      chk(q[6], 1);
      bus(0, `OFS_DATA, 0);
      chk(q, 32'h011);
      peer_u.send(frame(8'h60, 8'h33, n), n);
      wait_rx();
      chk(q, 32'h833);
      // Sixteen characters fill the receive FIFO
      cfg(8'h70);
      for (int i = 0; i < 16; i++) peer_u.send(frame(8'h70, 8'(i + 8'h40), n), n);
      bus(0, `OFS_FLAG, 0);
      chk(q[6], 1);
      chk(q[9], 1);
      for (int i = 0; i < 16; i++) begin
         bus(0, `OFS_DATA, 0);
         chk(q, 32'(i + 8'h40));
      end
      // Break sent on the output, then mark again
      cfg(8'h71);
      repeat (40) @(posedge clk);
      chk(serial_out_pin, 0);
      cfg(8'h70);
      repeat (40) @(posedge clk);
      chk(serial_out_pin, 1);
      // Infrared: idle line low, a zero bit leaves as a three-tick high pulse
      bus(1, `OFS_CTL, 32'h0302);
      bus(1, `OFS_CTL, 32'h0303);
      chk(serial_out_pin, 0);
      bus(1, `OFS_DATA, 32'h00);
      n = 0;
      while (serial_out_pin !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (serial_out_pin === 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk(n, 6);
      end_of_test();
   end
endmodule
